// ===== isa_cycle_ctrl.sv
`timescale 1ns/100ps
module isa_cycle_ctrl #(
    parameter int WAIT_8 = isa_pkg::WAIT_8BIT,
    parameter int WAIT_16 = isa_pkg::WAIT_16BIT
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic isa_clk,
    input wire logic req_valid,
    output logic req_ready,
    input wire isa_pkg::cyc_kind_e req_kind,
    input wire isa_pkg::cyc_op_e req_op,
    input wire logic [isa_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_bhe,
    input wire logic [isa_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [isa_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_wide,
    input wire logic fast_hold_ack,
    input wire logic fast_link_ready,
    output logic sysclk,
    output logic aen,
    output logic bale,
    input wire logic iochrdy_in,
    output logic iochrdy_out,
    output logic iochrdy_oe,
    input wire logic [3:0] cmd_n_in,
    output logic [3:0] cmd_n_out,
    output logic cmd_oe,
    output logic [isa_pkg::SA_W-1:0] sa_out,
    output logic sa_oe,
    input wire logic [isa_pkg::LA_W-1:0] la_in,
    output logic [isa_pkg::LA_W-1:0] la_out,
    output logic la_oe,
    output logic sbhe_n_out,
    output logic sbhe_n_oe,
    input wire logic [isa_pkg::DATA_W-1:0] sd_in,
    output logic [isa_pkg::DATA_W-1:0] sd_out,
    output logic sd_oe,
    input wire logic memcs16_n,
    input wire logic iocs16_n,
    input wire logic zerows_n,
    input wire logic master_n,
    output logic smemr_n,
    output logic smemw_n
);
    import isa_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_ALE, S_SIZE, S_CMD, S_DONE, S_MASTER} st_e;

    localparam logic [WAIT_CNT_W-1:0] LD_8 = WAIT_CNT_W'(WAIT_8 + SYNC_LAT);
    localparam logic [WAIT_CNT_W-1:0] LD_16 = WAIT_CNT_W'(WAIT_16 + SYNC_LAT);
    localparam logic [WAIT_CNT_W-1:0] LD_LAT = WAIT_CNT_W'(SYNC_LAT);

    logic isa_rst_s1_r;
    logic isa_rst_n_r;
    st_e st_r;
    isa_req_s cur_r;
    logic wide_r;
    logic [WAIT_CNT_W-1:0] wait_cnt_r;
    logic [DATA_W-1:0] rdata_r;
    logic sysclk_r;
    pin_s pins_raw;
    logic [$bits(pin_s)-1:0] pins_q;
    pin_s pins_s;
    isa_rsp_s rsp_s;
    logic busy;
    logic is_at;
    logic is_dma;
    logic is_ref;
    logic own_upper;
    logic m_upper;
    logic m_mem;
    logic cmd_end;
    logic pull_at;
    logic pull_dma;
    logic pull_mst;
    logic [3:0] own_cmd_n;

    xfer_if #(.RW($bits(isa_req_s)), .SW($bits(isa_rsp_s))) xf ();

    // Link-side reset: asserts at once, releases on the link clock
    always_ff @(posedge isa_clk or negedge resetn) begin
        if (!resetn) begin
            isa_rst_s1_r <= 1'h0;
            isa_rst_n_r <= 1'h0;
        end else begin
            isa_rst_s1_r <= 1'h1;
            isa_rst_n_r <= isa_rst_s1_r;
        end
    end

    req_handshake u_hs (
        .clk(clk),
        .resetn(resetn),
        .lclk(isa_clk),
        .lresetn(isa_rst_n_r),
        .x(xf.cdc)
    );

    // Request side on the system clock
    assign xf.s_valid = req_valid;
    assign xf.s_data = isa_req_s'{kind: req_kind, op: req_op, addr: req_addr,
        bhe: req_bhe, wdata: req_wdata};
    assign req_ready = xf.s_ready;
    assign rsp_valid = xf.s_done;
    assign rsp_s = isa_rsp_s'(xf.s_rsp);
    assign rsp_rdata = rsp_s.rdata;
    assign rsp_wide = rsp_s.wide;

    // Every bus pin and memory-side level passes two flops first
    assign pins_raw = '{master_n: master_n, chrdy: iochrdy_in, zerows_n: zerows_n,
        memcs16_n: memcs16_n, iocs16_n: iocs16_n, hold_ack: fast_hold_ack,
        link_rdy: fast_link_ready, cmd_n: cmd_n_in, la: la_in, sd: sd_in};

    bit_sync #(.W($bits(pin_s)), .RST(PIN_IDLE)) u_pins (
        .clk(isa_clk),
        .resetn(isa_rst_n_r),
        .d(pins_raw),
        .q(pins_q)
    );
    assign pins_s = pin_s'(pins_q);

    // Cycle decode
    assign busy = (st_r == S_ALE) || (st_r == S_SIZE) || (st_r == S_CMD) || (st_r == S_DONE);
    assign is_at = (cur_r.kind == KIND_AT);
    assign is_dma = (cur_r.kind == KIND_DMA);
    assign is_ref = (cur_r.kind == KIND_REFRESH);
    assign own_upper = (cur_r.addr[ADDR_W-1:LOW_MEG_LSB] != '0);
    assign m_upper = (pins_s.la[LA_W-1:LA_UP_OFS] != '0);
    assign m_mem = !pins_s.cmd_n[CMD_MEMR] || !pins_s.cmd_n[CMD_MEMW];

    // Wait over, then a slave may still stretch; zero-wait overrides both
    assign cmd_end = !pins_s.zerows_n ||
        ((wait_cnt_r == '0) && pins_s.chrdy &&
        (!(is_dma && own_upper) || pins_s.link_rdy));

    // Main cycle sequencer; a waiting master is served before a new request
    always_ff @(posedge isa_clk or negedge isa_rst_n_r) begin
        if (!isa_rst_n_r) begin
            st_r <= S_IDLE;
        end else begin
            unique case (st_r)
                S_IDLE: begin
                    if (!pins_s.master_n) begin
                        st_r <= S_MASTER;
                    end else if (xf.d_valid) begin
                        st_r <= S_ALE;
                    end
                end
                S_ALE: st_r <= S_SIZE;
                S_SIZE: st_r <= S_CMD;
                S_CMD: begin
                    if (cmd_end) begin
                        st_r <= S_DONE;
                    end
                end
                S_DONE: st_r <= S_IDLE;
                S_MASTER: begin
                    if (pins_s.master_n) begin
                        st_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Request word captured once it is known to be stable
    always_ff @(posedge isa_clk or negedge isa_rst_n_r) begin
        if (!isa_rst_n_r) begin
            cur_r <= '0;
        end else if (st_r == S_IDLE && pins_s.master_n && xf.d_valid) begin
            cur_r <= isa_req_s'(xf.d_data);
        end
    end

    // Size sampled before the command; refresh is always narrow
    always_ff @(posedge isa_clk or negedge isa_rst_n_r) begin
        if (!isa_rst_n_r) begin
            wide_r <= 1'h0;
            wait_cnt_r <= '0;
        end else if (st_r == S_SIZE) begin
            if (is_ref) begin
                wide_r <= 1'h0;
            end else if (cur_r.op == OP_MEM_RD || cur_r.op == OP_MEM_WR) begin
                wide_r <= !pins_s.memcs16_n;
            end else begin
                wide_r <= !pins_s.iocs16_n;
            end
            if (!is_at) begin
                wait_cnt_r <= LD_LAT;
            end else if (cur_r.op == OP_MEM_RD || cur_r.op == OP_MEM_WR) begin
                wait_cnt_r <= pins_s.memcs16_n ? LD_8 : LD_16;
            end else begin
                wait_cnt_r <= pins_s.iocs16_n ? LD_8 : LD_16;
            end
        end else if (st_r == S_CMD && wait_cnt_r != '0) begin
            wait_cnt_r <= wait_cnt_r - WAIT_CNT_W'(1);
        end
    end

    // Read data taken as the command ends
    always_ff @(posedge isa_clk or negedge isa_rst_n_r) begin
        if (!isa_rst_n_r) begin
            rdata_r <= '0;
        end else if (st_r == S_CMD && cmd_end) begin
            rdata_r <= pins_s.sd;
        end
    end

    // Bus clock at half the link clock; one link cycle is half a period
    always_ff @(posedge isa_clk or negedge isa_rst_n_r) begin
        if (!isa_rst_n_r) begin
            sysclk_r <= 1'h0;
        end else begin
            sysclk_r <= ~sysclk_r;
        end
    end
    assign sysclk = sysclk_r;

    assign xf.d_ack = (st_r == S_DONE);
    assign xf.d_rsp = {wide_r, rdata_r};

    // Strobes: refresh reads memory; DMA cycles carry the DMA unit's op
    assign own_cmd_n = is_ref ? ~(4'h1 << CMD_MEMR) : ~(4'h1 << cur_r.op);
    assign cmd_n_out = (st_r == S_CMD) ? own_cmd_n : CMD_IDLE;
    assign cmd_oe = (st_r != S_MASTER);

    // Address, enables and latch strobe
    assign aen = (st_r == S_MASTER) || (busy && is_dma);
    assign bale = pins_s.hold_ack || (busy && is_ref) ||
        (st_r == S_ALE && is_at);
    assign sa_out = cur_r.addr[SA_W-1:0];
    assign sa_oe = (st_r != S_MASTER);
    assign la_out = cur_r.addr[ADDR_W-1:LA_LSB];
    assign la_oe = (st_r != S_MASTER);
    assign sbhe_n_out = !(busy && cur_r.bhe);
    assign sbhe_n_oe = (st_r != S_MASTER);
    assign sd_out = cur_r.wdata;
    assign sd_oe = busy && !is_ref && (cur_r.op == OP_MEM_WR || cur_r.op == OP_IO_WR);

    // Low-meg strobes follow own memory commands or a master's, below 1 MB
    always_comb begin
        smemr_n = 1'h1;
        smemw_n = 1'h1;
        if (st_r == S_CMD && !own_upper) begin
            smemr_n = own_cmd_n[CMD_MEMR];
            smemw_n = own_cmd_n[CMD_MEMW];
        end else if (st_r == S_MASTER && !m_upper) begin
            smemr_n = pins_s.cmd_n[CMD_MEMR];
            smemw_n = pins_s.cmd_n[CMD_MEMW];
        end
    end

    // Channel ready: open drain, only ever pulled low
    assign pull_at = (st_r == S_CMD) && is_at && (wait_cnt_r > LD_LAT);
    assign pull_dma = (st_r == S_CMD) && is_dma && own_upper && !pins_s.link_rdy;
    assign pull_mst = (st_r == S_MASTER) && m_mem && m_upper && !pins_s.link_rdy;
    assign iochrdy_out = 1'h0;
    assign iochrdy_oe = pull_at || pull_dma || pull_mst;

    AST_AEN_MASTER: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_IDLE) |-> !aen)
        else $error("address enable high while idle");
    AST_BALE_PULSE: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_ALE && is_at) |-> bale ##1 (pins_s.hold_ack || !bale))
        else $error("latch pulse not one link cycle");
    AST_BALE_HOLD: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (pins_s.hold_ack || (st_r == S_CMD && is_ref)) |-> bale)
        else $error("latch enable low during hold or refresh");
    AST_WAIT_PULL: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_SIZE && is_at && !pins_s.memcs16_n && cur_r.op == OP_MEM_RD)
        |=> iochrdy_oe ##1 !iochrdy_oe)
        else $error("default wait pull wrong length");
    AST_STRETCH: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_CMD && wait_cnt_r == '0 && !pins_s.chrdy && pins_s.zerows_n)
        |=> (st_r == S_CMD) && (cmd_n_out != CMD_IDLE))
        else $error("command ended while channel not ready");
    AST_ZERO_WAIT: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_CMD && !pins_s.zerows_n) |=> (st_r == S_DONE) && (cmd_n_out == CMD_IDLE))
        else $error("zero wait did not end the cycle");
    AST_MASTER_OFF: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_IDLE && !pins_s.master_n) |=> !cmd_oe && !sa_oe && !la_oe && !sbhe_n_oe)
        else $error("device still drives bus under master");
    AST_LOW_MEG: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_CMD && (!smemr_n || !smemw_n)) |-> !own_upper)
        else $error("low-meg strobe above 1 MB");
    AST_UPPER_RDY: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_CMD && is_dma && own_upper && !pins_s.link_rdy)
        |-> iochrdy_oe ##1 (st_r == S_CMD))
        else $error("upper memory not held for link ready");
    AST_RDY_RELEASE: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r != S_CMD && st_r != S_MASTER) |-> !iochrdy_oe)
        else $error("channel ready pulled outside a cycle");

    // Cycle shape and pin ownership, checked against the pins; the size checks look at wide_r
    AST_CMD_ONE_HOT: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_CMD && !is_ref) |-> !cmd_n_out[cur_r.op] && ($countones(cmd_n_out) == 3))
        else $error("command strobe does not match the cycle op");
    AST_REF_STROBE: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_CMD && is_ref) |-> (cmd_n_out == 4'hE))
        else $error("refresh cycle without a memory read strobe");
    AST_MEM_WIDE: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_SIZE && !is_ref && (cur_r.op == OP_MEM_RD || cur_r.op == OP_MEM_WR)
        && !pins_s.memcs16_n) |=> wide_r)
        else $error("16-bit memory slave sized narrow");
    AST_IO_NARROW: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_SIZE && (cur_r.op == OP_IO_RD || cur_r.op == OP_IO_WR)
        && pins_s.iocs16_n) |=> !wide_r)
        else $error("8-bit I/O slave sized wide");
    AST_MST_PULL: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_MASTER && m_mem && m_upper && !pins_s.link_rdy) |-> iochrdy_oe && !iochrdy_out)
        else $error("master upper-memory access not held for link ready");
    AST_SBHE_IDLE: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_IDLE) |-> sbhe_n_out && sbhe_n_oe)
        else $error("byte-high enable active between cycles");
    AST_AEN_OWN: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (busy && !is_dma) |-> !aen)
        else $error("address enable high in a processor or refresh cycle");
    AST_ADDR_DRIVE: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r != S_MASTER) |-> sa_oe && la_oe)
        else $error("address lines released without a master");
    AST_DONE_QUIET: assert property (@(posedge isa_clk) disable iff (!isa_rst_n_r)
        (st_r == S_DONE) |-> (cmd_n_out == CMD_IDLE) && !iochrdy_oe)
        else $error("command or ready pull left on after the cycle");
endmodule : isa_cycle_ctrl

// ===== isa_pkg.sv
package isa_pkg;

    // Address map of the expansion bus
    localparam int ADDR_W = 24;
    localparam int SA_W = 20;
    localparam int LA_LSB = 17;
    localparam int LA_W = ADDR_W - LA_LSB;
    localparam int LOW_MEG_LSB = 20;
    localparam int LA_UP_OFS = LOW_MEG_LSB - LA_LSB;
    localparam int DATA_W = 16;

    // Default wait states, in link clock cycles
    localparam int WAIT_8BIT = 4;
    localparam int WAIT_16BIT = 1;
    localparam int WAIT_CNT_W = 4;
    // Depth of the pin synchronisers
    localparam int SYNC_LAT = 2;

    // Active-low command vector positions
    localparam int CMD_MEMR = 0;
    localparam int CMD_MEMW = 1;
    localparam int CMD_IOR = 2;
    localparam int CMD_IOW = 3;
    localparam logic [3:0] CMD_IDLE = 4'hF;

    typedef enum logic [1:0] {KIND_AT, KIND_DMA, KIND_REFRESH} cyc_kind_e;
    // Order matches the command vector positions
    typedef enum logic [1:0] {OP_MEM_RD, OP_MEM_WR, OP_IO_RD, OP_IO_WR} cyc_op_e;

    typedef struct packed {
        cyc_kind_e kind;
        cyc_op_e op;
        logic [ADDR_W-1:0] addr;
        logic bhe;
        logic [DATA_W-1:0] wdata;
    } isa_req_s;

    typedef struct packed {
        logic wide;
        logic [DATA_W-1:0] rdata;
    } isa_rsp_s;

    // Bus pins seen by the link-side logic
    typedef struct packed {
        logic master_n;
        logic chrdy;
        logic zerows_n;
        logic memcs16_n;
        logic iocs16_n;
        logic hold_ack;
        logic link_rdy;
        logic [3:0] cmd_n;
        logic [LA_W-1:0] la;
        logic [DATA_W-1:0] sd;
    } pin_s;

    localparam pin_s PIN_IDLE = '{master_n: 1'h1, chrdy: 1'h1, zerows_n: 1'h1,
        memcs16_n: 1'h1, iocs16_n: 1'h1, hold_ack: 1'h0, link_rdy: 1'h0,
        cmd_n: CMD_IDLE, la: 7'h00, sd: 16'h0000};

endpackage : isa_pkg

// ===== xfer_if.sv
`timescale 1ns/100ps
// Request word one way, answer word back, across two clocks
interface xfer_if #(parameter int RW = 1, parameter int SW = 1);
    logic s_valid;
    logic s_ready;
    logic [RW-1:0] s_data;
    logic s_done;
    logic [SW-1:0] s_rsp;
    logic d_valid;
    logic [RW-1:0] d_data;
    logic d_ack;
    logic [SW-1:0] d_rsp;
    modport cdc (input s_valid, s_data, d_ack, d_rsp,
        output s_ready, s_done, s_rsp, d_valid, d_data);
    modport user (output s_valid, s_data, d_ack, d_rsp,
        input s_ready, s_done, s_rsp, d_valid, d_data);
endinterface : xfer_if

// ===== bit_sync.sv
`timescale 1ns/100ps
module bit_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    // Two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= RST;
            q <= RST;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule : bit_sync

// ===== req_handshake.sv
`timescale 1ns/100ps
module req_handshake (
    input wire logic clk,
    input wire logic resetn,
    input wire logic lclk,
    input wire logic lresetn,
    xfer_if.cdc x
);
    localparam int RW = $bits(x.s_data);
    localparam int SW = $bits(x.s_rsp);

    logic busy_r;
    logic req_tgl_r;
    logic [RW-1:0] data_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_seen_r;
    logic done_r;
    logic [SW-1:0] s_rsp_r;
    logic req_s1_r;
    logic req_s2_r;
    logic req_seen_r;
    logic ack_tgl_r;
    logic [SW-1:0] rsp_hold_r;

    // Word held still until answered, so the far side may read it freely
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'h0;
            req_tgl_r <= 1'h0;
            data_r <= '0;
        end else if (x.s_valid && !busy_r) begin
            data_r <= x.s_data;
            req_tgl_r <= ~req_tgl_r;
            busy_r <= 1'h1;
        end else if (ack_s2_r != ack_seen_r) begin
            busy_r <= 1'h0;
        end
    end

    // Answer toggle back into the system clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_s1_r <= 1'h0;
            ack_s2_r <= 1'h0;
            ack_seen_r <= 1'h0;
            done_r <= 1'h0;
            s_rsp_r <= '0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_seen_r <= ack_s2_r;
            done_r <= (ack_s2_r != ack_seen_r);
            if (ack_s2_r != ack_seen_r) begin
                s_rsp_r <= rsp_hold_r;
            end
        end
    end

    // Request toggle into the link clock
    always_ff @(posedge lclk or negedge lresetn) begin
        if (!lresetn) begin
            req_s1_r <= 1'h0;
            req_s2_r <= 1'h0;
            req_seen_r <= 1'h0;
            ack_tgl_r <= 1'h0;
            rsp_hold_r <= '0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            if (x.d_ack && x.d_valid) begin
                req_seen_r <= req_s2_r;
                rsp_hold_r <= x.d_rsp;
                ack_tgl_r <= ~ack_tgl_r;
            end
        end
    end

    assign x.s_ready = !busy_r;
    assign x.s_done = done_r;
    assign x.s_rsp = s_rsp_r;
    assign x.d_valid = (req_s2_r != req_seen_r);
    assign x.d_data = data_r;
endmodule : req_handshake

// ===== isa_slave_model.sv
`timescale 1ns/100ps
// Expansion card: sizes itself, stretches or shortens commands, answers reads
module isa_slave_model (
    input wire logic isa_clk,
    input wire logic [3:0] cmd_n,
    input wire logic wide,
    input wire logic [7:0] stretch,
    input wire logic zws,
    input wire logic [15:0] rdata,
    input wire logic [15:0] sd_in,
    output logic memcs16_n,
    output logic iocs16_n,
    output logic zerows_n,
    output logic chrdy_pull,
    output logic [15:0] sd_drv,
    output logic [15:0] wseen_r
);
    logic active;
    logic [7:0] cnt_r;
    logic [15:0] last_r;
    assign active = cmd_n != 4'hF;
    // Size selects decoded from the card's own width
    assign memcs16_n = ~wide;
    assign iocs16_n = ~wide;
    // Zero-wait only while a command is active
    assign zerows_n = ~(zws & active);
    // Hold ready low for the first cycles of each command
    assign chrdy_pull = active && cnt_r < stretch;
    // Released data lines toggle so a stale value never looks valid
    assign sd_drv = (!cmd_n[0] || !cmd_n[2]) ? rdata : ~last_r;
    // Command age and captured write data
    always_ff @(posedge isa_clk) begin
        cnt_r <= active ? cnt_r + 8'h01 : 8'h00;
        last_r <= sd_drv;
        if (!cmd_n[1] || !cmd_n[3]) begin
            wseen_r <= sd_in;
        end
    end
endmodule : isa_slave_model

// ===== isa_cycle_ctrl_tb_top.sv
`timescale 1ns/100ps
module isa_cycle_ctrl_tb_top;
    import isa_pkg::*;
    localparam int W8 = 4;
    localparam int W16 = 1;
    logic clk = 0, isa_clk = 0, resetn = 0, req_valid = 0, req_bhe = 0;
    logic fast_hold_ack = 0, fast_link_ready = 1, master_n = 1, wide = 0, zws = 0;
    cyc_kind_e req_kind = KIND_AT;
    cyc_op_e req_op = OP_MEM_RD;
    logic [23:0] req_addr = 0;
    logic [15:0] req_wdata = 0, rsp_rdata, sd_in, sd_out, sd_drv, wseen, rdata = 0;
    logic req_ready, rsp_valid, rsp_wide, sysclk, aen, bale, iochrdy_in, iochrdy_out;
    logic iochrdy_oe, cmd_oe, sa_oe, la_oe, sbhe_n_out, sbhe_n_oe, sd_oe, pull;
    logic memcs16_n, iocs16_n, zerows_n, smemr_n, smemw_n;
    logic [3:0] cmd_n_in, cmd_n_out, mst_cmd = 4'hF;
    logic [19:0] sa_out;
    logic [6:0] la_in, la_out, mst_la = 0;
    logic [7:0] stretch = 0;
    int fail_count = 0, n_checks = 0;
    logic [3:0] m_cmd;
    logic [1:0] m_smem;
    logic [19:0] m_sa;
    logic [6:0] m_la;
    logic m_sbhe;
    int m_len, m_oe, m_bale, m_aen, m_blo;
    always #5 clk = ~clk;
    always #7.5 isa_clk = ~isa_clk;
    // Open-drain ready and shared lines resolved from every driver
    assign iochrdy_in = !(iochrdy_oe && !iochrdy_out) && !pull;
    assign cmd_n_in = cmd_oe ? cmd_n_out : mst_cmd;
    assign la_in = la_oe ? la_out : mst_la;
    assign sd_in = sd_oe ? sd_out : sd_drv;
    isa_cycle_ctrl #(.WAIT_8(W8), .WAIT_16(W16)) u_isa_cycle_ctrl (.clk, .resetn, .isa_clk,
        .req_valid, .req_ready, .req_kind, .req_op, .req_addr, .req_bhe, .req_wdata,
        .rsp_valid, .rsp_rdata, .rsp_wide, .fast_hold_ack, .fast_link_ready, .sysclk,
        .aen, .bale, .iochrdy_in, .iochrdy_out, .iochrdy_oe, .cmd_n_in, .cmd_n_out,
        .cmd_oe, .sa_out, .sa_oe, .la_in, .la_out, .la_oe, .sbhe_n_out, .sbhe_n_oe,
        .sd_in, .sd_out, .sd_oe, .memcs16_n, .iocs16_n, .zerows_n, .master_n,
        .smemr_n, .smemw_n);
    isa_slave_model u_isa_slave_model (.isa_clk, .cmd_n(cmd_n_in), .wide, .stretch,
        .zws, .rdata, .sd_in, .memcs16_n, .iocs16_n, .zerows_n, .chrdy_pull(pull),
        .sd_drv, .wseen_r(wseen));
    // Bus observations; counts and strobe sets cleared before each request, sampled address and byte-high kept
    always @(posedge isa_clk) begin
        if (cmd_oe && cmd_n_out != CMD_IDLE) begin
            m_cmd <= m_cmd | ~cmd_n_out;
            m_len <= m_len + 1;
            m_blo <= m_blo + int'(!bale);
            m_sa <= sa_out;
            m_la <= la_out;
            m_sbhe <= sbhe_n_out;
            m_smem <= m_smem | ~{smemw_n, smemr_n};
        end
        m_oe <= m_oe + int'(iochrdy_oe);
        m_bale <= m_bale + int'(bale);
        m_aen <= m_aen + int'(aen);
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Low-meg strobes only for memory ops below 1 MB
    function automatic logic [1:0] exp_smem(input cyc_op_e o, input logic [23:0] a);
        return (a[23:20] == 4'h0 && o <= OP_MEM_WR) ? 2'(1 << o) : 2'h0;
    endfunction : exp_smem
    task automatic chk_v(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk_v
    task automatic chk_c(input string nm, input int e, input int g);
        n_checks++;
        if (g != e) begin
            fail_count++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_c
    task automatic complete_run;
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    // One request, entered at a falling edge; returns at the answer
    task automatic run(input cyc_kind_e k, input cyc_op_e o, input logic [23:0] a,
        input logic b, input logic [15:0] d);
        int t;
        t = 0;
        {m_cmd, m_smem, m_len, m_oe, m_bale, m_aen, m_blo} = '0;
        while (req_ready !== 1'b1 && t < 2000) begin
            @(negedge clk);
            t++;
        end
        req_kind = k;
        req_op = o;
        req_addr = a;
        req_bhe = b;
        req_wdata = d;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 0;
        while (rsp_valid !== 1'b1 && t < 2000) begin
            @(negedge clk);
            t++;
        end
        chk_c("answer", 1, int'(t < 2000));
    endtask : run
    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    initial begin
        logic [31:0] r;
        logic [23:0] a;
        cyc_op_e o;
        logic s;
        r = 32'h7AE7;
        repeat (6) @(negedge clk);
        resetn = 1;
        // Random processor cycles over every op, width and region
        repeat (24) begin
            r = lfsr(r);
            o = cyc_op_e'(r[1:0]);
            a = r[6] ? {4'h0, r[27:8]} : r[31:8];
            wide = r[4];
            rdata = r[23:8] ^ 16'hA5C3;
            run(KIND_AT, o, a, r[5], r[31:16]);
            chk_c("bale_len", 1, m_bale);
            chk_c("aen_at", 0, m_aen);
            chk_c("pull_len", wide ? W16 : W8, m_oe);
            chk_v("cmd", 1 << o, m_cmd);
            chk_v("smem", exp_smem(o, a), m_smem);
            chk_v("sa", a[19:0], m_sa);
            chk_v("la", a[23:17], m_la);
            chk_v("sbhe", !r[5], m_sbhe);
            chk_v("wide", wide, rsp_wide);
            if (o == OP_MEM_RD || o == OP_IO_RD)
                chk_v("rdata", rdata, rsp_rdata);
            else
                chk_v("wdata", r[31:16], wseen);
            chk_v("chrdy_rel", 0, iochrdy_oe);
        end
        // Zero-wait beats the default count, slave ready stretches it
        wide = 0;
        zws = 1;
        run(KIND_AT, OP_MEM_RD, 24'h0ABCDE, 1'b0, 16'h0000);
        chk_c("zws_short", 1, int'(m_len < W8 + 2));
        zws = 0;
        stretch = 8'h0C;
        run(KIND_AT, OP_IO_WR, 24'h000378, 1'b0, 16'h1234);
        chk_c("stretch", 1, int'(m_len >= 12));
        stretch = 0;
        run(KIND_REFRESH, OP_MEM_RD, 24'h000040, 1'b0, 16'h0000);
        chk_c("bale_ref", 0, m_blo);
        chk_v("cmd_ref", 1, m_cmd);
        run(KIND_DMA, OP_IO_WR, 24'h000300, 1'b0, 16'h00FF);
        chk_c("aen_dma", 1, int'(m_aen > 0));
        chk_v("cmd_dma", 8, m_cmd);
        // Upper-memory DMA waits on the memory controller
        fast_link_ready = 0;
        fork
            run(KIND_DMA, OP_MEM_RD, 24'h200010, 1'b1, 16'h0000);
            begin
                repeat (60) @(negedge clk);
                chk_v("link_pull", 1, iochrdy_oe);
                chk_v("cmd_held", 0, cmd_n_out[0]);
                fast_link_ready = 1;
            end
        join
        fast_hold_ack = 1;
        repeat (8) @(negedge clk);
        chk_v("bale_hold", 1, bale);
        fast_hold_ack = 0;
        // External master takes the bus
        master_n = 0;
        repeat (10) @(negedge clk);
        chk_v("cmd_oe", 0, cmd_oe);
        chk_v("addr_oe", 0, {sa_oe, la_oe, sbhe_n_oe});
        chk_v("aen_mst", 1, aen);
        mst_la = 7'h10;
        mst_cmd = 4'hE;
        fast_link_ready = 0;
        repeat (10) @(negedge clk);
        chk_v("mst_pull", 1, iochrdy_oe);
        fast_link_ready = 1;
        repeat (10) @(negedge clk);
        chk_v("mst_rel", 0, iochrdy_oe);
        mst_cmd = CMD_IDLE;
        master_n = 1;
        repeat (10) @(negedge clk);
        chk_v("cmd_oe_back", 1, cmd_oe);
        // Bus clock must flip on every link clock cycle
        @(negedge isa_clk);
        s = sysclk;
        @(negedge isa_clk);
        chk_v("sysclk", !s, sysclk);
        complete_run();
    end
endmodule : isa_cycle_ctrl_tb_top
